// [verilog/piwd_board.sv]
// window decoder and acknowledge logic of the fieldbus board
`timescale 1ns/1ps
module piwd_board (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // backplane
  piwd_bus_if.board bus,
  // switch and jumper settings
  input wire logic [7:0] win_in_base_i,
  input wire logic [7:0] win_in_len_i,
  input wire logic [7:0] win_out_base_i,
  input wire logic [7:0] win_out_len_i,
  input wire logic win_ext_i,
  input wire logic [7:0] comm_base_i,
  input wire logic comm_ext_i,
  input wire logic window_acknowledge_mode_i,
  input wire logic logical_addr_i,
  input wire logic controlled_start_i,
  input wire logic irq_enable_i,
  input wire logic ack_delay_on_err_i,
  // module map
  input wire logic [piwd_pkg::NMOD-1:0] mod_present_i,
  input wire logic [piwd_pkg::NMOD-1:0] mod_expected_i,
  input wire logic [piwd_pkg::NMOD-1:0][2:0] mod_in_words_i,
  input wire logic [piwd_pkg::NMOD-1:0][2:0] mod_out_words_i,
  input wire logic [piwd_pkg::NMOD-1:0][7:0] mod_in_base_i,
  input wire logic [piwd_pkg::NMOD-1:0][7:0] mod_out_base_i,
  // module data
  output logic [2:0] mod_rd_mod_o,
  output logic [2:0] mod_rd_off_o,
  input wire logic [15:0] mod_rd_data_i,
  output logic mod_wr_stb_o,
  output logic [2:0] mod_wr_mod_o,
  output logic [2:0] mod_wr_off_o,
  output logic [15:0] wr_data_o,
  // communication and command registers
  input wire logic [31:0] comm_in_i,
  output logic comm_wr_stb_o,
  output logic comm_wr_idx_o,
  output logic cmd_wr_stb_o,
  // diagnostics and status
  input wire logic remote_bus_fault_i,
  input wire logic local_bus_fault_i,
  input wire logic ctrl_fault_i,
  input wire logic module_fault_i,
  input wire logic [15:0] err_param_i,
  input wire logic io_ready_i,
  input wire logic irq_req_i,
  input wire logic [7:0] irq_num_i,
  output logic ack_withheld_o,
  output logic removal_blind_o
);
  typedef struct packed {
    logic busy;
    piwd_pkg::piwd_kind_t kind;
    logic off;
    logic ack;
    logic [15:0] rdata;
    logic [2:0] rd_mod;
    logic [2:0] rd_off;
    logic wr_stb;
    logic [2:0] wr_mod;
    logic [2:0] wr_off;
    logic [15:0] wr_data;
    logic comm_stb;
    logic comm_idx;
    logic cmd_stb;
    logic [piwd_pkg::NFLT-1:0] f1;
    logic [piwd_pkg::NFLT-1:0] f2;
    logic [piwd_pkg::NFLT-1:0] f3;
    logic [piwd_pkg::NFLT-1:0] flt;
    logic [15:0] eparam;
    logic io_ready;
    logic irq;
    logic blind;
    logic withhold;
  } piwd_bst_t;

  piwd_bst_t q;
  piwd_bst_t d;
  piwd_pkg::piwd_kind_t kind;
  logic [2:0] hmod;
  logic [2:0] hoff;
  logic hoff1;
  logic [8:0] aw;
  logic [8:0] wbase;
  logic [8:0] run;
  logic [8:0] mb;
  logic [2:0] words;
  logic use_log;
  logic mismatch;
  logic in_win;
  logic [15:0] diag_word;

  // true when byte address a lies in [base, base+len)
  function automatic logic in_rng(input logic [8:0] a,
                                  input logic [8:0] base,
                                  input logic [8:0] len);
    logic [8:0] diff;
    diff = a - base;
    return (a >= base) && (diff < len);
  endfunction : in_rng

  // word offset of byte address a from base
  function automatic logic [2:0] woff(input logic [8:0] a,
                                      input logic [8:0] base);
    logic [8:0] diff;
    diff = a - base;
    return diff[3:1];
  endfunction : woff

  always_comb begin
    d = q;
    d.ack = 1'b0;
    d.wr_stb = 1'b0;
    d.comm_stb = 1'b0;
    d.cmd_stb = 1'b0;
    // fault pins: three stages, a change counts once stages two and three agree
    d.f1 = {module_fault_i, ctrl_fault_i, local_bus_fault_i,
            remote_bus_fault_i};
    d.f2 = q.f1;
    d.f3 = q.f2;
    if (q.f2 == q.f3) begin
      d.flt = q.f3;
    end
    d.eparam = err_param_i;
    d.io_ready = io_ready_i;
    d.irq = irq_req_i & irq_enable_i;
    mismatch = logical_addr_i && (mod_present_i != mod_expected_i);
    use_log = logical_addr_i | (controlled_start_i &
              ~window_acknowledge_mode_i);
    d.blind = ~use_log;
    d.withhold = ack_delay_on_err_i & (|q.flt);
    // decode is word granular, byte 1 follows byte 0
    aw = {1'b0, bus.addr[7:1], 1'b0};
    kind = piwd_pkg::K_NONE;
    hmod = 3'h0;
    hoff = 3'h0;
    hoff1 = 1'b0;
    wbase = bus.wr ? {1'b0, win_out_base_i} : {1'b0, win_in_base_i};
    run = wbase;
    mb = wbase;
    words = 3'h0;
    in_win = in_rng(aw, wbase, bus.wr ? {1'b0, win_out_len_i} :
                    {1'b0, win_in_len_i});
    // communication words win over every other setting
    if (bus.ext == comm_ext_i &&
        in_rng(aw, {1'b0, comm_base_i}, piwd_pkg::COMM_BYTES)) begin
      kind = piwd_pkg::K_COMM;
      hoff1 = aw[1];
    end else if (!bus.wr && !bus.ext && irq_enable_i &&
                 aw[7:0] == piwd_pkg::IRQ_WORD_ADDR) begin
      kind = piwd_pkg::K_IRQ;
    end else if (bus.ext == win_ext_i) begin
      // diagnostic and command words sit just below the window bases
      if (!bus.wr && in_rng(aw, wbase - piwd_pkg::DIAG_BYTES,
                            piwd_pkg::DIAG_BYTES)) begin
        kind = piwd_pkg::K_DIAG;
        hoff1 = aw[1];
      end else if (bus.wr && in_rng(aw, wbase - piwd_pkg::CMD_BYTES,
                                    piwd_pkg::CMD_BYTES)) begin
        kind = piwd_pkg::K_CMD;
      end else begin
        for (int i = 0; i < piwd_pkg::NMOD; i++) begin
          words = bus.wr ? mod_out_words_i[i] : mod_in_words_i[i];
          mb = use_log ? {1'b0, (bus.wr ? mod_out_base_i[i] :
                                 mod_in_base_i[i]) & 8'hFE} : run;
          if (kind == piwd_pkg::K_NONE && mod_present_i[i] &&
              words != 3'h0 && in_rng(aw, mb, {5'h00, words, 1'b0})) begin
            kind = piwd_pkg::K_MOD;
            hmod = 3'(i);
            hoff = woff(aw, mb);
          end
          // undetected modules take no addresses
          if (mod_present_i[i]) begin
            run = run + {5'h00, words, 1'b0};
          end
        end
        // window mode answers module addresses only inside the windows, gaps read zero
        if (window_acknowledge_mode_i) begin
          if (!in_win) begin
            kind = piwd_pkg::K_NONE;
          end else if (kind == piwd_pkg::K_NONE) begin
            kind = piwd_pkg::K_GAP;
          end
        end
      end
    end
    // accept: writes are passed on at once, reads answer next cycle
    // the error jumper never silences the communication words
    if (bus.req && !q.busy && kind != piwd_pkg::K_NONE &&
        (!q.withhold || kind == piwd_pkg::K_COMM)) begin
      d.busy = 1'b1;
      d.kind = kind;
      d.off = hoff1;
      d.rd_mod = hmod;
      d.rd_off = hoff;
      if (bus.wr) begin
        d.wr_data = bus.wdata;
        d.wr_mod = hmod;
        d.wr_off = hoff;
        d.wr_stb = (kind == piwd_pkg::K_MOD);
        d.comm_stb = (kind == piwd_pkg::K_COMM);
        d.comm_idx = hoff1;
        d.cmd_stb = (kind == piwd_pkg::K_CMD);
      end
    end
    diag_word = 16'h0000;
    diag_word[piwd_pkg::NFLT-1:0] = q.flt;
    diag_word[piwd_pkg::DIAG_MISMATCH] = mismatch;
    // answer phase: rdata stands with the one-cycle acknowledge
    if (q.busy) begin
      d.busy = 1'b0;
      d.ack = 1'b1;
      d.kind = piwd_pkg::K_NONE;
      case (q.kind)
        piwd_pkg::K_COMM: d.rdata = q.off ? comm_in_i[15:0] :
                                    comm_in_i[31:16];
        piwd_pkg::K_IRQ: d.rdata = {irq_num_i, 8'h00};
        piwd_pkg::K_DIAG: d.rdata = q.off ? q.eparam : diag_word;
        piwd_pkg::K_MOD: d.rdata = mod_rd_data_i;
        default: d.rdata = piwd_pkg::RDATA_RST;
      endcase
    end
  end

  // single state register; faults reset to clear
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  // outputs straight from the state register
  assign bus.ack = q.ack;
  assign bus.rdata = q.rdata;
  assign bus.io_ready = q.io_ready;
  assign bus.irq = q.irq;
  assign mod_rd_mod_o = q.rd_mod;
  assign mod_rd_off_o = q.rd_off;
  assign mod_wr_stb_o = q.wr_stb;
  assign mod_wr_mod_o = q.wr_mod;
  assign mod_wr_off_o = q.wr_off;
  assign wr_data_o = q.wr_data;
  assign comm_wr_stb_o = q.comm_stb;
  assign comm_wr_idx_o = q.comm_idx;
  assign cmd_wr_stb_o = q.cmd_stb;
  assign ack_withheld_o = q.withhold;
  assign removal_blind_o = q.blind;
endmodule : piwd_board

// [verilog/piwd_pkg.sv]
// shared constants and types of the backplane window decoder and plc end
package piwd_pkg;
  // backplane address spaces
  localparam int AREA_BYTES = 256;
  localparam int IMAGE_BYTES = 128;
  localparam int IMAGE_WORDS = IMAGE_BYTES / 2;
  localparam int NMOD = 8;
  // board register windows, sizes in bytes, and the interrupt word address
  localparam logic [8:0] COMM_BYTES = 9'h004;
  localparam logic [8:0] DIAG_BYTES = 9'h004;
  localparam logic [8:0] CMD_BYTES = 9'h002;
  localparam logic [7:0] IRQ_WORD_ADDR = 8'h00;
  // diagnostic status word bit positions
  localparam int FLT_RB = 0;
  localparam int FLT_LB = 1;
  localparam int FLT_CTRL = 2;
  localparam int FLT_MOD = 3;
  localparam int DIAG_MISMATCH = 4;
  localparam int NFLT = 4;
  // reset values
  localparam logic [15:0] RDATA_RST = 16'h0000;
  localparam logic [7:0] ADDR_RST = 8'h00;
  // plc waits this long for an acknowledgement before giving up
  localparam int CLK_PERIOD_NS = 20;
  localparam int ACK_TIMEOUT_NS = 10000;
  localparam int ACK_TIMEOUT_CYC = ACK_TIMEOUT_NS / CLK_PERIOD_NS;
  // what an accepted backplane access hit
  typedef enum logic [2:0] {
    K_NONE = 3'h0,
    K_COMM = 3'h1,
    K_IRQ = 3'h2,
    K_DIAG = 3'h3,
    K_CMD = 3'h4,
    K_MOD = 3'h5,
    K_GAP = 3'h6
  } piwd_kind_t;
  // plc end sequencer states
  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_ISSUE = 2'h1,
    ST_WAIT = 2'h2
  } piwd_hst_t;
endpackage : piwd_pkg

// [verilog/piwd_bus_if.sv]
// backplane io bus between plc cpu and window decoder board
`timescale 1ns/1ps
interface piwd_bus_if (
  input wire logic clk_i,
  input wire logic rst_i
);
  logic req;
  logic wr;
  logic ext;
  logic [7:0] addr;
  logic [15:0] wdata;
  logic ack;
  logic [15:0] rdata;
  logic io_ready;
  logic irq;
  modport plc (
    output req, wr, ext, addr, wdata,
    input ack, rdata, io_ready, irq
  );
  modport board (
    input req, wr, ext, addr, wdata,
    output ack, rdata, io_ready, irq
  );
endinterface : piwd_bus_if

// [verilog/piwd_plc.sv]
// plc cpu end: scan of the process image and direct word access
`timescale 1ns/1ps
module piwd_plc (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // backplane
  piwd_bus_if.plc bus,
  // direct word access from the application
  input wire logic app_cmd_i,
  input wire logic app_wr_i,
  input wire logic app_ext_i,
  input wire logic [7:0] app_addr_i,
  input wire logic [15:0] app_wdata_i,
  output logic app_done_o,
  output logic app_timeout_o,
  output logic app_refused_o,
  output logic [15:0] app_rdata_o,
  // process image access
  input wire logic [5:0] img_rd_idx_i,
  output logic [15:0] img_rd_data_o,
  input wire logic img_wr_i,
  input wire logic [5:0] img_wr_idx_i,
  input wire logic [15:0] img_wr_data_i,
  // scan and startup
  input wire logic scan_start_i,
  output logic scan_busy_o,
  output logic app_run_o,
  output logic irq_o
);
  typedef struct packed {
    piwd_pkg::piwd_hst_t st;
    logic scan;
    logic [6:0] sidx;
    logic [9:0] tmo;
    logic req;
    logic wr;
    logic ext;
    logic [7:0] addr;
    logic [15:0] wdata;
    logic done;
    logic timeout;
    logic refused;
    logic [15:0] rdata;
    logic [15:0] img_rd;
    logic run;
    logic irq;
    logic [piwd_pkg::IMAGE_WORDS-1:0][15:0] in_img;
    logic [piwd_pkg::IMAGE_WORDS-1:0][15:0] out_img;
  } piwd_pst_t;

  localparam logic [9:0] TMO_LAST = 10'(piwd_pkg::ACK_TIMEOUT_CYC - 1);
  localparam logic [7:0] IMG_LIMIT = 8'(piwd_pkg::IMAGE_BYTES);

  piwd_pst_t q;
  piwd_pst_t d;

  always_comb begin
    d = q;
    d.req = 1'b0;
    d.done = 1'b0;
    d.timeout = 1'b0;
    d.refused = 1'b0;
    d.irq = bus.irq;
    // application leaves startup once the board offers io data
    if (bus.io_ready) begin
      d.run = 1'b1;
    end
    d.img_rd = q.in_img[img_rd_idx_i];
    if (img_wr_i) begin
      d.out_img[img_wr_idx_i] = img_wr_data_i;
    end
    case (q.st)
      piwd_pkg::ST_IDLE: begin
        if (scan_start_i && q.run) begin
          d.scan = 1'b1;
          d.sidx = 7'h00;
          d.st = piwd_pkg::ST_ISSUE;
        end else if (app_cmd_i) begin
          // image bytes are reached through the image, not directly
          if (!app_ext_i && app_addr_i < IMG_LIMIT) begin
            d.refused = 1'b1;
          end else begin
            d.scan = 1'b0;
            d.req = 1'b1;
            d.wr = app_wr_i;
            d.ext = app_ext_i;
            d.addr = {app_addr_i[7:1], 1'b0};
            d.wdata = app_wdata_i;
            d.tmo = 10'h000;
            d.st = piwd_pkg::ST_WAIT;
          end
        end
      end
      piwd_pkg::ST_ISSUE: begin
        // first half of the scan reads inputs, second half writes outputs
        d.req = 1'b1;
        d.wr = q.sidx[6];
        d.ext = 1'b0;
        d.addr = {1'b0, q.sidx[5:0], 1'b0};
        d.wdata = q.out_img[q.sidx[5:0]];
        d.tmo = 10'h000;
        d.st = piwd_pkg::ST_WAIT;
      end
      piwd_pkg::ST_WAIT: begin
        if (bus.ack || q.tmo == TMO_LAST) begin
          if (q.scan) begin
            // an unanswered input word keeps its old image value
            if (bus.ack && !q.wr) begin
              d.in_img[q.sidx[5:0]] = bus.rdata;
            end
            d.sidx = q.sidx + 7'h01;
            d.st = (q.sidx == 7'h7F) ? piwd_pkg::ST_IDLE :
                   piwd_pkg::ST_ISSUE;
            d.scan = (q.sidx != 7'h7F);
          end else begin
            d.done = bus.ack;
            d.timeout = ~bus.ack;
            d.rdata = bus.ack ? bus.rdata : piwd_pkg::RDATA_RST;
            d.st = piwd_pkg::ST_IDLE;
          end
        end else begin
          d.tmo = q.tmo + 10'h001;
        end
      end
      default: d.st = piwd_pkg::ST_IDLE;
    endcase
  end

  // single state register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign bus.req = q.req;
  assign bus.wr = q.wr;
  assign bus.ext = q.ext;
  assign bus.addr = q.addr;
  assign bus.wdata = q.wdata;
  assign app_done_o = q.done;
  assign app_timeout_o = q.timeout;
  assign app_refused_o = q.refused;
  assign app_rdata_o = q.rdata;
  assign img_rd_data_o = q.img_rd;
  assign scan_busy_o = q.scan;
  assign app_run_o = q.run;
  assign irq_o = q.irq;
endmodule : piwd_plc

// [verification/piwd_properties.sv]
// backplane handshake assertions for the window decoder link
`timescale 1ns/1ps
module piwd_properties #(
  parameter logic [7:0] COMM_BASE = 8'hF0,
  parameter logic [31:0] COMM_IN = 32'h0000_0000
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // backplane signals
  input wire logic req,
  input wire logic wr,
  input wire logic ext,
  input wire logic [7:0] addr,
  input wire logic [15:0] wdata,
  input wire logic ack,
  input wire logic [15:0] rdata,
  input wire logic io_ready,
  input wire logic irq
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  // requests into the communication window, primary space only
  sequence s_comm;
    req && !ext && addr[7:2] == COMM_BASE[7:2];
  endsequence
  sequence s_comm_rd0;
    s_comm ##0 (!wr && !addr[1]);
  endsequence
  // input word 0 of the primary area, interrupt enable held on
  sequence s_irq_rd;
    req && !wr && !ext && addr[7:1] == 7'h00;
  endsequence
  a_ack_from_req: assert property (
    ack |-> $past(req, 2) && !$past(req))
    else $error("ack without request two cycles earlier");
  a_ack_one_cycle: assert property (ack |=> !ack)
    else $error("ack longer than one cycle");
  a_req_spacing: assert property (req |=> !req [*2])
    else $error("request issued before answer");
  a_comm_always: assert property (s_comm |-> ##2 ack)
    else $error("communication word not acknowledged");
  a_comm_word: assert property (
    s_comm_rd0 ##2 ack |-> rdata == COMM_IN[31:16])
    else $error("communication word 0 data wrong");
  a_irq_claim: assert property (s_irq_rd |-> ##2 ack)
    else $error("interrupt word not claimed");
  a_irq_ident: assert property (
    s_irq_rd ##2 ack |-> rdata[7:0] == 8'h00)
    else $error("interrupt word low byte not zero");
  a_rdata_on_ack: assert property ($changed(rdata) |-> ack)
    else $error("read data moved outside ack");
  a_wdata_held: assert property ($changed(wdata) |-> req)
    else $error("write data moved outside request");
endmodule : piwd_properties

// [verification/plc_io_window_decoder_test.sv]
// bench joining the plc end and the decoder board over the backplane
`timescale 1ns/1ps
module plc_io_window_decoder_test;
  localparam logic [15:0] DONE = 16'h0001;
  localparam logic [15:0] TOUT = 16'h0002;
  localparam logic [15:0] REFD = 16'h0004;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  // switch settings; mode and error jumper move during the run
  logic [7:0] win_in_base_i = 8'hC0;
  logic [7:0] win_in_len_i = 8'h10;
  logic [7:0] win_out_base_i = 8'hC0;
  logic [7:0] win_out_len_i = 8'h10;
  logic [7:0] comm_base_i = 8'hF0;
  logic window_acknowledge_mode_i = 1'b0;
  logic logical_addr_i = 1'b0;
  logic controlled_start_i = 1'b0;
  logic irq_enable_i = 1'b1;
  logic ack_delay_on_err_i = 1'b0;
  // only modules 0 and 2 present, module 2 two words, the rest one word
  logic [7:0] mod_present_i = 8'h05;
  logic [7:0] mod_expected_i = 8'h05;
  logic [7:0][2:0] mod_words = 24'h249289;
  // logical bases, only read while logical or controlled addressing is on
  logic [7:0][7:0] mod_base = 64'h0000_0000_0000_0000;
  logic [15:0] mod_rd_data_i;
  logic [31:0] comm_in_i = 32'h1234_5678;
  logic remote_bus_fault_i = 1'b0;
  logic local_bus_fault_i = 1'b0;
  logic ctrl_fault_i = 1'b0;
  logic module_fault_i = 1'b0;
  logic [15:0] err_param_i = 16'h0B07;
  logic io_ready_i = 1'b0;
  logic irq_req_i = 1'b1;
  logic [7:0] irq_num_i = 8'h5C;
  logic [2:0] mod_rd_mod_o, mod_rd_off_o, mod_wr_mod_o, mod_wr_off_o;
  logic mod_wr_stb_o, comm_wr_stb_o, comm_wr_idx_o, cmd_wr_stb_o;
  logic [15:0] wr_data_o;
  logic ack_withheld_o, removal_blind_o;
  // plc application side
  logic app_cmd_i = 1'b0;
  logic app_wr_i = 1'b0;
  logic app_ext_i = 1'b0;
  logic [7:0] app_addr_i = 8'h00;
  logic [15:0] app_wdata_i = 16'h0000;
  logic app_done_o, app_timeout_o, app_refused_o;
  logic [15:0] app_rdata_o, img_rd_data_o;
  logic [5:0] img_rd_idx_i = 6'h00;
  logic img_wr_i = 1'b0;
  logic [5:0] img_wr_idx_i = 6'h00;
  logic [15:0] img_wr_data_i = 16'h0000;
  logic scan_start_i = 1'b0;
  logic scan_busy_o, app_run_o, irq_o;
  logic [15:0] wtag, wdat, res, rdv;
  int miscompares = 0;
  int checked = 0;
  // module data tags each word with its module and offset
  assign mod_rd_data_i = {8'hA0, 1'b0, mod_rd_mod_o, 1'b0, mod_rd_off_o};
  piwd_bus_if piwd_bus_if_inst (.clk_i, .rst_i);
  piwd_board piwd_board_inst (.clk_i, .rst_i, .bus(piwd_bus_if_inst),
    .win_in_base_i, .win_in_len_i, .win_out_base_i, .win_out_len_i,
    .win_ext_i(1'b0), .comm_base_i, .comm_ext_i(1'b0),
    .window_acknowledge_mode_i, .logical_addr_i, .controlled_start_i,
    .irq_enable_i, .ack_delay_on_err_i, .mod_present_i, .mod_expected_i,
    .mod_in_words_i(mod_words), .mod_out_words_i(mod_words),
    .mod_in_base_i(mod_base), .mod_out_base_i(mod_base), .mod_rd_mod_o,
    .mod_rd_off_o, .mod_rd_data_i, .mod_wr_stb_o, .mod_wr_mod_o,
    .mod_wr_off_o, .wr_data_o,
    .comm_in_i, .comm_wr_stb_o, .comm_wr_idx_o, .cmd_wr_stb_o,
    .remote_bus_fault_i, .local_bus_fault_i, .ctrl_fault_i, .module_fault_i,
    .err_param_i, .io_ready_i, .irq_req_i, .irq_num_i, .ack_withheld_o,
    .removal_blind_o);
  piwd_plc piwd_plc_inst (.clk_i, .rst_i, .bus(piwd_bus_if_inst), .app_cmd_i,
    .app_wr_i, .app_ext_i, .app_addr_i, .app_wdata_i, .app_done_o,
    .app_timeout_o, .app_refused_o, .app_rdata_o, .img_rd_idx_i,
    .img_rd_data_o, .img_wr_i, .img_wr_idx_i, .img_wr_data_i, .scan_start_i,
    .scan_busy_o, .app_run_o, .irq_o);
  piwd_properties #(.COMM_BASE(8'hF0), .COMM_IN(32'h1234_5678))
    piwd_properties_inst (.clk_i, .rst_i, .req(piwd_bus_if_inst.req),
    .wr(piwd_bus_if_inst.wr), .ext(piwd_bus_if_inst.ext),
    .addr(piwd_bus_if_inst.addr), .wdata(piwd_bus_if_inst.wdata),
    .ack(piwd_bus_if_inst.ack), .rdata(piwd_bus_if_inst.rdata),
    .io_ready(piwd_bus_if_inst.io_ready), .irq(piwd_bus_if_inst.irq));
  // latch the kind and target of every board-side write strobe
  always @(posedge clk_i) begin
    if (mod_wr_stb_o | comm_wr_stb_o | cmd_wr_stb_o) begin
      wtag <= {mod_wr_stb_o, cmd_wr_stb_o, comm_wr_stb_o, comm_wr_idx_o,
               mod_wr_mod_o, mod_wr_off_o, 6'h00};
      wdat <= wr_data_o;
    end
  end
  initial begin
    forever #10 clk_i = ~clk_i;
  end
  task automatic chk(input logic [15:0] g, input logic [15:0] e,
                     input string m);
    checked++;
    if (g !== e) begin
      miscompares++;
      $display("[ERR] %0t %s: got %h exp %h", $time, m, g, e);
    end
  endtask : chk
  // one direct word access; result bits are refused, timeout, done
  task automatic acc(input logic w, input logic x, input logic [7:0] a,
                     input logic [15:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    app_cmd_i <= 1'b1;
    app_wr_i <= w;
    app_ext_i <= x;
    app_addr_i <= a;
    app_wdata_i <= d;
    @(posedge clk_i);
    app_cmd_i <= 1'b0;
    res = 16'h0000;
    while (res == 16'h0000 && n < 600) begin
      @(negedge clk_i);
      n++;
      res = {13'h0000, app_refused_o, app_timeout_o, app_done_o};
    end
    rdv = app_rdata_o;
  endtask : acc
  task automatic rdc(input logic x, input logic [7:0] a,
                     input logic [15:0] r, input logic [15:0] e);
    acc(1'b0, x, a, 16'h0000);
    chk(res, r, "read result");
    if (r == DONE) chk(rdv, e, "read data");
  endtask : rdc
  task automatic t_module;
    rdc(1'b0, 8'hC0, DONE, 16'hA000);
    rdc(1'b0, 8'hC3, DONE, 16'hA020);
    rdc(1'b0, 8'hC4, DONE, 16'hA021);
    rdc(1'b0, 8'hC6, TOUT, 16'h0000);
    acc(1'b1, 1'b0, 8'hC4, 16'h5A3C);
    chk(wtag & 16'hEFC0, 16'h8440, "module write");
    chk(wdat, 16'h5A3C, "module write data");
    chk({15'h0, removal_blind_o}, 16'h0001, "removal blind");
  endtask : t_module
  task automatic t_window;
    @(posedge clk_i);
    window_acknowledge_mode_i <= 1'b1;
    rdc(1'b0, 8'hC6, DONE, 16'h0000);
    rdc(1'b0, 8'hD0, TOUT, 16'h0000);
    rdc(1'b1, 8'hC4, TOUT, 16'h0000);
    rdc(1'b0, 8'h7E, REFD, 16'h0000);
    acc(1'b1, 1'b0, 8'hBE, 16'h0F0F);
    chk(wtag & 16'hE000, 16'h4000, "command write");
  endtask : t_window
  task automatic t_comm;
    rdc(1'b0, 8'hF0, DONE, 16'h1234);
    rdc(1'b0, 8'hF3, DONE, 16'h5678);
    acc(1'b1, 1'b0, 8'hF2, 16'hC3A5);
    chk(wtag & 16'hF000, 16'h3000, "comm write");
    chk(wdat, 16'hC3A5, "comm write data");
  endtask : t_comm
  // logical bases and presence check, then controlled start in module mode
  task automatic t_logical;
    @(posedge clk_i);
    logical_addr_i <= 1'b1;
    mod_expected_i <= 8'h07;
    mod_base[2] <= 8'hCB;
    rdc(1'b0, 8'hCA, DONE, 16'hA020);
    rdc(1'b0, 8'hBC, DONE, 16'h0010);
    chk({15'h0, removal_blind_o}, 16'h0000, "blind in logical");
    @(posedge clk_i);
    logical_addr_i <= 1'b0;
    controlled_start_i <= 1'b1;
    window_acknowledge_mode_i <= 1'b0;
    mod_expected_i <= 8'h05;
    rdc(1'b0, 8'hCD, DONE, 16'hA021);
    @(posedge clk_i);
    controlled_start_i <= 1'b0;
  endtask : t_logical
  task automatic t_diag;
    @(posedge clk_i);
    remote_bus_fault_i <= 1'b1;
    repeat (6) @(posedge clk_i);
    rdc(1'b0, 8'hBC, DONE, 16'h0001);
    rdc(1'b0, 8'hBE, DONE, 16'h0B07);
    @(posedge clk_i);
    ack_delay_on_err_i <= 1'b1;
    repeat (2) @(negedge clk_i);
    chk({15'h0, ack_withheld_o}, 16'h0001, "ack withheld");
    rdc(1'b0, 8'hC0, TOUT, 16'h0000);
    rdc(1'b0, 8'hF0, DONE, 16'h1234);
    @(posedge clk_i);
    remote_bus_fault_i <= 1'b0;
    repeat (6) @(posedge clk_i);
    rdc(1'b0, 8'hC0, DONE, 16'hA000);
  endtask : t_diag
  task automatic t_scan;
    int n;
    n = 0;
    chk({15'h0, app_run_o}, 16'h0000, "run before ready");
    @(posedge clk_i);
    io_ready_i <= 1'b1;
    repeat (4) @(negedge clk_i);
    chk({15'h0, app_run_o}, 16'h0001, "run after ready");
    chk({15'h0, irq_o}, 16'h0001, "irq seen");
    @(posedge clk_i);
    scan_start_i <= 1'b1;
    @(posedge clk_i);
    scan_start_i <= 1'b0;
    repeat (2) @(negedge clk_i);
    while (scan_busy_o && n < 70000) begin
      @(negedge clk_i);
      n++;
    end
    chk({15'h0, scan_busy_o}, 16'h0000, "scan end");
    repeat (2) @(negedge clk_i);
    chk(img_rd_data_o, 16'h5C00, "interrupt number");
  endtask : t_scan
  task automatic finish_test;
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : finish_test
  // scan alone waits out about 64000 cycles of undecoded accesses
  initial begin
    repeat (90000) @(posedge clk_i);
    miscompares++;
    finish_test;
  end
  initial begin
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    t_module;
    t_window;
    t_comm;
    t_logical;
    t_diag;
    t_scan;
    finish_test;
  end
endmodule : plc_io_window_decoder_test
